// File: pcc_pkg.sv
// Purpose: shared constants and types of the pipe control block
// Assumes: CORE_CLK at 100 MHz, APB register access, 32-bit data
// Notes:   one word per register, printed offsets are byte addresses
`default_nettype none

package pcc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERR    = 8'h08;

  localparam int CTRL_LOOP_BIT    = 0;
  localparam int CTRL_SETTLE_LSB  = 8;
  localparam int STAT_PS_LSB      = 0;
  localparam int STAT_FOUND_BIT   = 2;
  localparam int STAT_PSBUSY_BIT  = 3;
  localparam int STAT_DETBUSY_BIT = 4;
  localparam int ERR_IDLE_BIT     = 0;
  localparam int ERR_REQ_BIT      = 1;

  localparam logic [7:0] SETTLE_RST = 8'h04;
  localparam logic       LOOP_RST   = 1'b1;

  // ****************************************************************
  // link codes
  // ****************************************************************
  typedef enum logic [1:0] {
    PS_P0  = 2'b00,
    PS_P0S = 2'b01,
    PS_P1  = 2'b10,
    PS_P2  = 2'b11
  } pcc_ps_type;

  localparam logic [2:0] STAT_OK       = 3'b000;
  localparam logic [2:0] STAT_RX_FOUND = 3'b011;
  localparam logic [2:0] STAT_RX_NONE  = 3'b001;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int IDLE_MIN_NS    = 20;
  localparam int IDLE_MIN_CYC   =
    (IDLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DET_TIMEOUT_NS = 10000;
  localparam int DET_TIMEOUT_CYC = DET_TIMEOUT_NS / CLK_PERIOD_NS;

endpackage : pcc_pkg

`default_nettype wire

// File: pcc_det_if.sv
// Purpose: handshake between control logic and detect sequencer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`default_nettype none

interface pcc_det_if;
  logic start;
  logic busy;
  logic done;
  logic found;

  modport ctrl (output start, input busy, input done, input found);
  modport seq  (input start, output busy, output done, output found);
endinterface : pcc_det_if

`default_nettype wire

// File: pcc_rxdet_seq.sv
// Purpose: runs one receiver detect sequence on the analog circuit
// Assumes: analog result inputs synchronous to CORE_CLK
// Notes:   a missing answer ends as not found after a timeout
`default_nettype none

module pcc_rxdet_seq
  import pcc_pkg::*;
#(
  parameter int TIMEOUT_CYC = pcc_pkg::DET_TIMEOUT_CYC
)(
  // clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RST_B,
  // control side
  pcc_det_if.seq    det,
  // analog detect circuit
  output logic      RXDET_CMD,
  input  wire logic RXDET_DONE,
  input  wire logic RXDET_FOUND
);

  typedef enum logic {SQ_IDLE, SQ_RUN} pcc_sq_type;

  typedef struct packed {
    pcc_sq_type  st;
    logic [15:0] cnt;
    logic        cmd;
    logic        done;
    logic        found;
  } pcc_seq_type;

  localparam pcc_seq_type SEQ_RST = '{SQ_IDLE, 16'h0000, 1'b0, 1'b0,
                                      1'b0};

  pcc_seq_type s;
  pcc_seq_type next_s;

  initial
  begin
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535)
      $error("pcc_rxdet_seq: TIMEOUT_CYC out of range");
  end

  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    unique case (s.st)
      SQ_IDLE:
      begin
        if (det.start)
        begin
          next_s.st  = SQ_RUN;
          next_s.cmd = 1'b1;
          next_s.cnt = 16'(TIMEOUT_CYC - 1);
        end
      end
      SQ_RUN:
      begin
        // a silent analog circuit must not hang the link training
        if (RXDET_DONE || s.cnt == 16'h0000)
        begin
          next_s.st    = SQ_IDLE;
          next_s.cmd   = 1'b0;
          next_s.done  = 1'b1;
          next_s.found = RXDET_DONE & RXDET_FOUND;
        end
        else
          next_s.cnt = s.cnt - 16'h0001;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      s <= SEQ_RST;
    else
      s <= next_s;
  end

  assign RXDET_CMD  = s.cmd;
  assign det.busy   = (s.st == SQ_RUN);
  assign det.done   = s.done;
  assign det.found  = s.found;

  a_det_bounded: assert property (
    @(posedge CORE_CLK) disable iff (!RST_B)
    $rose(s.cmd) |-> ##[1:TIMEOUT_CYC] s.done)
    else $error("detect sequence did not finish in time");

endmodule : pcc_rxdet_seq

`default_nettype wire

// File: pcc_pipe_ctrl.sv
// Purpose: phy-side power, idle, detect and disparity control
// Assumes: pipe inputs synchronous to CORE_CLK, APB3 slave, no wait
// Notes:   transmit data and its disparity flag pass one flop stage
//
// Local design decisions: the APB slave port and the register addresses.
`default_nettype none

module pcc_pipe_ctrl
  import pcc_pkg::*;
#(
  parameter int DATA_W      = 16,
  parameter int TIMEOUT_CYC = pcc_pkg::DET_TIMEOUT_CYC
)(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_B,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // pipe requests from link controller
  input  wire pcc_pkg::pcc_ps_type POWER_STATE_REQ,
  input  wire logic              FORCE_TX_IDLE,
  input  wire logic              DETECT_RX_OR_LOOPBACK_REQ,
  input  wire logic              FORCE_NEG_DISPARITY,
  input  wire logic [DATA_W-1:0] TX_DATA,
  // pipe answers to link controller
  output logic                   PHY_OP_DONE,
  output logic      [2:0]        RX_STATUS_CODE,
  // transmit datapath controls
  output logic      [DATA_W-1:0] TX_DATA_OUT,
  output logic                   TX_NEG_DISP,
  output logic                   TX_ELEC_IDLE,
  output logic                   TX_BEACON,
  output logic                   LOOPBACK_EN,
  // analog detect circuit
  output logic                   RXDET_CMD,
  input  wire logic              RXDET_DONE,
  input  wire logic              RXDET_FOUND
);

  initial
  begin
    if (DATA_W != 8 && DATA_W != 16)
      $error("pcc_pipe_ctrl: DATA_W must be 8 or 16");
    if (IDLE_MIN_CYC < 1 || IDLE_MIN_CYC > 15)
      $error("pcc_pipe_ctrl: idle hold does not fit its counter");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pcc_ps_type        cur;
    pcc_ps_type        tgt;
    logic              ps_busy;
    logic [7:0]        settle_cnt;
    logic              idle;
    logic [3:0]        idle_cnt;
    logic              det_req_q;
    logic              det_start;
    logic              last_found;
    logic              done;
    logic [2:0]        status;
    logic              loopback;
    logic              beacon;
    logic [DATA_W-1:0] data;
    logic              neg_disp;
    logic [7:0]        settle;
    logic              loop_allow;
    logic [1:0]        err;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } pcc_st_type;

  localparam pcc_st_type ST_RST = '{
    cur: PS_P1, tgt: PS_P1, ps_busy: 1'b0, settle_cnt: 8'h00,
    idle: 1'b1, idle_cnt: 4'h0, det_req_q: 1'b0, det_start: 1'b0,
    last_found: 1'b0, done: 1'b0, status: STAT_OK, loopback: 1'b0,
    beacon: 1'b0, data: '0, neg_disp: 1'b0, settle: SETTLE_RST,
    loop_allow: LOOP_RST, err: 2'b00, pready: 1'b0, pslverr: 1'b0,
    prdata: 32'h0000_0000};

  localparam logic [3:0] IDLE_HOLD = 4'(IDLE_MIN_CYC - 1);

  pcc_st_type s;
  pcc_st_type next_s;

  pcc_det_if det ();

  // ****************************************************************
  // receiver detect sequencer
  // ****************************************************************
  pcc_rxdet_seq #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_rxdet (
    .CORE_CLK    (CORE_CLK),
    .RST_B       (RST_B),
    .det         (det.seq),
    .RXDET_CMD   (RXDET_CMD),
    .RXDET_DONE  (RXDET_DONE),
    .RXDET_FOUND (RXDET_FOUND)
  );

  assign det.start = s.det_start;

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic is_mapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_ERR;
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input pcc_st_type st,
                                          input logic det_busy);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      REG_CTRL:
      begin
        w[CTRL_LOOP_BIT] = st.loop_allow;
        w[CTRL_SETTLE_LSB +: 8] = st.settle;
      end
      REG_STATUS:
      begin
        w[STAT_PS_LSB +: 2]   = st.cur;
        w[STAT_FOUND_BIT]     = st.last_found;
        w[STAT_PSBUSY_BIT]    = st.ps_busy;
        w[STAT_DETBUSY_BIT]   = det_busy;
      end
      REG_ERR:
        w[1:0] = st.err;
      default:
        w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  logic want_idle;
  logic setup;
  logic access;
  logic wr_err;
  logic [1:0] err_set;

  always_comb
  begin
    next_s           = s;
    next_s.done      = 1'b0;
    next_s.status    = STAT_OK;
    next_s.det_start = 1'b0;

    // P0s and P1 force the transmitter idle, P0 and P2 follow FORCE_TX_IDLE
    unique case (s.cur)
      PS_P0:  want_idle = FORCE_TX_IDLE;
      PS_P0S: want_idle = 1'b1;
      PS_P1:  want_idle = 1'b1;
      PS_P2:  want_idle = FORCE_TX_IDLE;
    endcase

    // hold idle long enough to meet the minimum residency
    next_s.idle = want_idle | (s.idle & (s.idle_cnt != 4'h0));
    if (!s.idle)
      next_s.idle_cnt = IDLE_HOLD;
    else if (s.idle_cnt != 4'h0)
      next_s.idle_cnt = s.idle_cnt - 4'h1;

    next_s.beacon   = (s.cur == PS_P2) & ~FORCE_TX_IDLE;
    next_s.loopback = (s.cur == PS_P0) & DETECT_RX_OR_LOOPBACK_REQ
                      & s.loop_allow;

    // data and its disparity flag stay aligned through one stage
    next_s.data     = TX_DATA;
    next_s.neg_disp = FORCE_NEG_DISPARITY;

    // power state change
    if (!s.ps_busy)
    begin
      if (POWER_STATE_REQ != s.cur && !det.busy && !s.det_start)
      begin
        next_s.ps_busy    = 1'b1;
        next_s.tgt        = POWER_STATE_REQ;
        next_s.settle_cnt = s.settle;
      end
    end
    else if (s.settle_cnt == 8'h00)
    begin
      next_s.cur     = s.tgt;
      next_s.ps_busy = 1'b0;
      next_s.done    = 1'b1;
    end
    else
      next_s.settle_cnt = s.settle_cnt - 8'h01;

    // detect start on the request edge, only settled in P1
    next_s.det_req_q = DETECT_RX_OR_LOOPBACK_REQ;
    if (s.cur == PS_P1 && !s.ps_busy && !det.busy && !s.det_start
        && DETECT_RX_OR_LOOPBACK_REQ && !s.det_req_q
        // a move and a detect must never start in one cycle
        && POWER_STATE_REQ == PS_P1)
      next_s.det_start = 1'b1;

    if (det.done)
    begin
      next_s.done       = 1'b1;
      next_s.last_found = det.found;
      if (det.found)
        next_s.status = STAT_RX_FOUND;
      else
        next_s.status = STAT_RX_NONE;
    end

    // apb: answer in the cycle after setup, never stalls
    setup          = PSEL & ~PENABLE;
    access         = PSEL & PENABLE & s.pready;
    next_s.pready  = setup;
    next_s.pslverr = setup & ~is_mapped(PADDR);
    next_s.prdata  = (setup && !PWRITE) ?
                     rd_word(PADDR, s, det.busy) : 32'h0000_0000;
    wr_err = access & PWRITE & (PADDR == REG_ERR);
    if (access && PWRITE && PADDR == REG_CTRL)
    begin
      next_s.loop_allow = PWDATA[CTRL_LOOP_BIT];
      next_s.settle     = PWDATA[CTRL_SETTLE_LSB +: 8];
    end

    // sticky flags: a new event beats a clear in the same cycle
    err_set[ERR_IDLE_BIT] = ~s.ps_busy & ~FORCE_TX_IDLE &
                            (s.cur == PS_P0S || s.cur == PS_P1);
    err_set[ERR_REQ_BIT]  = s.ps_busy & (POWER_STATE_REQ != s.tgt);
    next_s.err = (s.err & ~(wr_err ? PWDATA[1:0] : 2'b00)) | err_set;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      s <= ST_RST;
    else
      s <= next_s;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA         = s.prdata;
  assign PREADY         = s.pready;
  assign PSLVERR        = s.pslverr;
  assign PHY_OP_DONE    = s.done;
  assign RX_STATUS_CODE = s.status;
  assign TX_DATA_OUT    = s.data;
  assign TX_NEG_DISP    = s.neg_disp;
  assign TX_ELEC_IDLE   = s.idle;
  assign TX_BEACON      = s.beacon;
  assign LOOPBACK_EN    = s.loopback;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence seq_ps_start;
    !s.ps_busy ##1 s.ps_busy;
  endsequence

  sequence seq_ps_end;
    ##[1:257] (s.done && !s.ps_busy && s.cur == s.tgt);
  endsequence

  a_ps_done: assert property (seq_ps_start |-> seq_ps_end)
    else $error("power transition did not complete");

  a_done_single: assert property (
    $rose(PHY_OP_DONE) && !det.done |=> !PHY_OP_DONE)
    else $error("done pulse longer than one cycle");

  a_force_idle: assert property (
    FORCE_TX_IDLE |=> TX_ELEC_IDLE)
    else $error("force idle not honoured");

  a_idle_min: assert property (
    $rose(TX_ELEC_IDLE) |-> TX_ELEC_IDLE [*2])
    else $error("idle left too early");

  a_p1_idle: assert property (
    s.cur == PS_P1 && $past(s.cur) == PS_P1 |-> TX_ELEC_IDLE)
    else $error("transmitter active in P1");

  a_p0s_idle: assert property (
    s.cur == PS_P0S && $past(s.cur) == PS_P0S |->
      TX_ELEC_IDLE && !TX_BEACON)
    else $error("transmitter active in P0s");

  a_det_in_p1: assert property (
    s.det_start |-> s.cur == PS_P1 && !s.ps_busy)
    else $error("detect started outside P1");

  a_det_found: assert property (
    det.done && det.found |=>
      PHY_OP_DONE && RX_STATUS_CODE == 3'b011)
    else $error("found receiver misreported");

  a_det_absent: assert property (
    det.done && !det.found |=>
      PHY_OP_DONE && RX_STATUS_CODE == 3'b001)
    else $error("absent receiver misreported");

  a_status_quiet: assert property (
    !PHY_OP_DONE |-> RX_STATUS_CODE == 3'b000)
    else $error("status code not zero");

  a_neg_disp: assert property (
    FORCE_NEG_DISPARITY |=> TX_NEG_DISP &&
      TX_DATA_OUT == $past(TX_DATA))
    else $error("disparity flag lost its data");

  a_beacon_p2: assert property (
    TX_BEACON |-> $past(s.cur) == PS_P2 && !$past(FORCE_TX_IDLE))
    else $error("beacon outside P2");

  a_loop_p0: assert property (
    LOOPBACK_EN |-> $past(s.cur) == PS_P0 &&
      $past(DETECT_RX_OR_LOOPBACK_REQ))
    else $error("loopback outside P0");

  a_p2_output: assert property (
    s.cur == PS_P2 && $past(s.cur) == PS_P2 |->
      TX_ELEC_IDLE || TX_BEACON)
    else $error("P2 sends neither idle nor beacon");

  a_move_no_det: assert property (
    s.ps_busy |-> !det.busy)
    else $error("detect running during power move");

  a_ps_code: assert property (
    PHY_OP_DONE && !$past(det.done) |->
      RX_STATUS_CODE == 3'b000)
    else $error("power done with nonzero status");

endmodule : pcc_pipe_ctrl

`default_nettype wire

// File: pcc_link_model.sv
// Purpose: link controller model driving the pipe requests
// Assumes: CORE_CLK shared with the control block
// Notes:   bench steers it through tasks; no free-running traffic
`default_nettype none

module pcc_link_model
  import pcc_pkg::*;
(
  // clock and answers
  input  wire logic                CORE_CLK,
  input  wire logic                PHY_OP_DONE,
  // requests to the phy
  output var pcc_pkg::pcc_ps_type  POWER_STATE_REQ,
  output var logic                 FORCE_TX_IDLE,
  output var logic                 DETECT_RX_OR_LOOPBACK_REQ,
  output var logic                 FORCE_NEG_DISPARITY,
  output var logic [15:0]          TX_DATA
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // request helpers
  // ****************************************************************
  initial
  begin
    POWER_STATE_REQ           = PS_P1;
    FORCE_TX_IDLE             = 1'b1;
    DETECT_RX_OR_LOOPBACK_REQ = 1'b0;
    FORCE_NEG_DISPARITY       = 1'b0;
    TX_DATA                   = 16'h0000;
  end

  // idle low only in P0 or while a beacon goes out in P2
  function automatic logic idle_for(pcc_ps_type ps, logic beacon);
    return ps != PS_P0 && !(ps == PS_P2 && beacon);
  endfunction

  task automatic drive(pcc_ps_type ps, logic idle, logic det);
    @(posedge CORE_CLK);
    POWER_STATE_REQ           <= ps;
    FORCE_TX_IDLE             <= idle;
    DETECT_RX_OR_LOOPBACK_REQ <= det;
  endtask

  // detect stays low while moving, so a move into P1 starts no detect
  task automatic go(pcc_ps_type ps, logic beacon, output int n);
    drive(ps, idle_for(ps, beacon), 1'b0);
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    while (PHY_OP_DONE !== 1'b1 && n < 300);
  endtask

  task automatic send(logic [15:0] d, logic neg);
    @(posedge CORE_CLK);
    TX_DATA             <= d;
    FORCE_NEG_DISPARITY <= neg;
  endtask
endmodule // pcc_link_model

`default_nettype wire

// File: pcc_pipe_ctrl_tb.sv
// Purpose: self-checking bench of the pipe control block
// Assumes: link model drives pipe requests, bench drives apb
// Notes:   analog detect answer is driven here directly
`default_nettype none

module pcc_pipe_ctrl_tb;
  import pcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CORE_CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        PHY_OP_DONE, TX_NEG_DISP, TX_ELEC_IDLE, TX_BEACON, er;
  logic        LOOPBACK_EN, RXDET_CMD, RXDET_DONE, RXDET_FOUND;
  logic        FORCE_TX_IDLE, DETECT_RX_OR_LOOPBACK_REQ, FORCE_NEG_DISPARITY;
  logic [2:0]  RX_STATUS_CODE;
  logic [15:0] TX_DATA, TX_DATA_OUT;
  logic [15:0] w [12];
  logic        ng [12];
  logic [7:0]  settle;
  pcc_ps_type  POWER_STATE_REQ;
  pcc_ps_type  cur_ps, nx;
  int          failures, total_checks, m;

  pcc_pipe_ctrl #(.DATA_W(16), .TIMEOUT_CYC(20)) u_pcc_pipe_ctrl (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_STATE_REQ(POWER_STATE_REQ),
    .FORCE_TX_IDLE(FORCE_TX_IDLE),
    .DETECT_RX_OR_LOOPBACK_REQ(DETECT_RX_OR_LOOPBACK_REQ),
    .FORCE_NEG_DISPARITY(FORCE_NEG_DISPARITY), .TX_DATA(TX_DATA),
    .PHY_OP_DONE(PHY_OP_DONE), .RX_STATUS_CODE(RX_STATUS_CODE),
    .TX_DATA_OUT(TX_DATA_OUT), .TX_NEG_DISP(TX_NEG_DISP),
    .TX_ELEC_IDLE(TX_ELEC_IDLE), .TX_BEACON(TX_BEACON),
    .LOOPBACK_EN(LOOPBACK_EN), .RXDET_CMD(RXDET_CMD),
    .RXDET_DONE(RXDET_DONE), .RXDET_FOUND(RXDET_FOUND));

  pcc_link_model u_pcc_link_model (
    .CORE_CLK(CORE_CLK), .PHY_OP_DONE(PHY_OP_DONE),
    .POWER_STATE_REQ(POWER_STATE_REQ), .FORCE_TX_IDLE(FORCE_TX_IDLE),
    .DETECT_RX_OR_LOOPBACK_REQ(DETECT_RX_OR_LOOPBACK_REQ),
    .FORCE_NEG_DISPARITY(FORCE_NEG_DISPARITY), .TX_DATA(TX_DATA));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  task automatic print_verdict();
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // a wait that runs out ends the run as failed
  task automatic bound(int n, int lim);
    if (n >= lim)
    begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic tick();
    @(posedge CORE_CLK);
    #1;
  endtask

  task automatic wait_done(int lim);
    int n;
    n = 0;
    while (PHY_OP_DONE !== 1'b1 && n < lim)
    begin
      tick();
      n++;
    end
    bound(n, lim);
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    #1;
    while (PREADY !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    bound(n, 20);
    rd = PRDATA;
    er = PSLVERR;
    @(posedge CORE_CLK);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic exp_idle(pcc_ps_type ps, logic beacon);
    return ps != PS_P0 && !(ps == PS_P2 && beacon);
  endfunction

  // mode 0 receiver found, 1 none found, 2 analog side silent
  task automatic detect(int mode);
    int n;
    u_pcc_link_model.drive(PS_P1, 1'b1, 1'b1);
    n = 0;
    while (RXDET_CMD !== 1'b1 && n < 10)
    begin
      tick();
      n++;
    end
    bound(n, 10);
    check("det_idle", TX_ELEC_IDLE, 1'b1);
    if (mode < 2)
    begin
      repeat ($urandom_range(1, 6)) @(posedge CORE_CLK);
      // stands in for the fixed-clock detect monitor
      RXDET_DONE  <= 1'b1;
      RXDET_FOUND <= (mode == 0);
      @(posedge CORE_CLK);
      RXDET_DONE  <= 1'b0;
      RXDET_FOUND <= (mode != 0);
    end
    wait_done(60);
    check("det_code", RX_STATUS_CODE,
          mode == 0 ? STAT_RX_FOUND : STAT_RX_NONE);
    tick();
    check("det_len", PHY_OP_DONE, 1'b0);
    check("det_after", RX_STATUS_CODE, STAT_OK);
    u_pcc_link_model.drive(PS_P1, 1'b1, 1'b0);
  endtask

  task automatic power(pcc_ps_type ps);
    int n;
    settle = 8'($urandom_range(1, 8));
    apb(1'b1, REG_CTRL, {16'h0000, settle, 8'h01});
    u_pcc_link_model.go(ps, 1'b0, n);
    bound(n, 300);
    check("done_lat", 32'(n), 32'(settle) + 32'h2);
    check("done_code", RX_STATUS_CODE, STAT_OK);
    tick();
    check("done_len", PHY_OP_DONE, 1'b0);
    tick();
    tick();
    check("idle_state", TX_ELEC_IDLE, exp_idle(ps, 1'b0));
    apb(1'b0, REG_STATUS, 32'h0);
    check("state_rd", rd[1:0], ps);
    cur_ps = ps;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    failures = 0;
    total_checks = 0;
    void'($urandom(32'h97f4f8bd));
    {RST_B, PSEL, PENABLE, PWRITE, RXDET_DONE, RXDET_FOUND} = 6'h00;
    PADDR  = 8'h00;
    PWDATA = 32'h0;
    repeat (6) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    tick();
    check("rst_idle", TX_ELEC_IDLE, 1'b1);
    check("rst_code", RX_STATUS_CODE, STAT_OK);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl_rst", rd, {16'h0000, SETTLE_RST, 7'h00, LOOP_RST});
    apb(1'b1, 8'h0c, 32'hffffffff);
    check("unmapped", er, 1'b1);
    apb(1'b1, REG_STATUS, 32'hffffffff);
    apb(1'b0, REG_STATUS, 32'h0);
    check("status_ro", rd[1:0], PS_P1);
    for (int k = 0; k < 3; k++)
      detect(k);
    // a request equal to the current state is never answered
    cur_ps = PS_P1;
    foreach (w[i])
    begin
      do
        nx = pcc_ps_type'($urandom_range(0, 3));
      while (nx == cur_ps || (i == 11 && nx == PS_P0S));
      power(nx);
    end
    power(PS_P0S);
    power(PS_P2);
    power(PS_P0);
    u_pcc_link_model.drive(PS_P0, 1'b0, 1'b1);
    repeat (3) tick();
    check("loop_on", LOOPBACK_EN, 1'b1);
    check("loop_idle", TX_ELEC_IDLE, 1'b0);
    apb(1'b1, REG_CTRL, {16'h0000, settle, 8'h00});
    repeat (2) tick();
    check("loop_off", LOOPBACK_EN, 1'b0);
    u_pcc_link_model.drive(PS_P0, 1'b1, 1'b0);
    repeat (3) tick();
    check("idle_held", TX_ELEC_IDLE, 1'b1);
    u_pcc_link_model.drive(PS_P0, 1'b0, 1'b0);
    repeat (4) tick();
    u_pcc_link_model.drive(PS_P0, 1'b1, 1'b0);
    u_pcc_link_model.drive(PS_P0, 1'b0, 1'b0);
    #1;
    m = int'(TX_ELEC_IDLE === 1'b1);
    repeat (6)
    begin
      tick();
      m += (TX_ELEC_IDLE === 1'b1);
    end
    check("idle_min", m >= 2 && m <= 3, 1'b1);
    foreach (w[i])
    begin
      w[i]  = 16'($urandom);
      ng[i] = 1'($urandom);
    end
    {w[4], ng[4], w[5], ng[5]} = {16'hb5bc, 1'b1, 16'h4abc, 1'b0};
    for (int i = 0; i < 13; i++)
    begin
      u_pcc_link_model.send(w[i % 12], ng[i % 12]);
      #1;
      if (i > 0)
      begin
        check("tx_data", TX_DATA_OUT, w[i - 1]);
        check("tx_disp", TX_NEG_DISP, ng[i - 1]);
      end
    end
    apb(1'b1, REG_CTRL, 32'h00000801);
    u_pcc_link_model.drive(PS_P1, 1'b1, 1'b0);
    repeat (2) tick();
    u_pcc_link_model.drive(PS_P2, 1'b1, 1'b0);
    wait_done(40);
    tick();
    wait_done(40);
    apb(1'b0, REG_ERR, 32'h0);
    check("err_busy", rd[ERR_REQ_BIT], 1'b1);
    apb(1'b1, REG_ERR, 32'h2);
    apb(1'b0, REG_ERR, 32'h0);
    check("err_clear", rd[ERR_REQ_BIT], 1'b0);
    u_pcc_link_model.drive(PS_P2, 1'b0, 1'b0);
    repeat (3) tick();
    check("beacon_on", TX_BEACON, 1'b1);
    u_pcc_link_model.drive(PS_P2, 1'b1, 1'b0);
    repeat (3) tick();
    check("beacon_off", TX_BEACON, 1'b0);
    check("p2_idle", TX_ELEC_IDLE, 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmap_rd", {er, rd}, {1'b1, 32'h0});
    print_verdict();
  end
endmodule // pcc_pipe_ctrl_tb

`default_nettype wire
